/* core/isq_mem.v */
`timescale 1ns/10ps
`default_nettype none

module isq_mem #(
  parameter DW = 24,
  parameter AW = 4
) (
  input  wire          i_clk,   // Clock
  input  wire          i_ce,    // Clock enable
  input  wire [AW-1:0] i_raddr, // Read address
  output reg  [DW-1:0] o_rdata, // Registered read data
  input  wire          i_we,    // Write enable
  input  wire [AW-1:0] i_waddr, // Write address
  input  wire [DW-1:0] i_wdata  // Write data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
    end
  end

endmodule // isq_mem

`default_nettype wire

/* core/isq_top.v */
//Contract
// RQ1 - Sixteen identical SAR sections run together, sharing one reference set.
// RQ2 - A sixteen-phase counter from the input clock times every section event.
// RQ3 - Results leave through a sixteen-to-one mux carrying nine bits per section.
// RQ4 - Every section takes exactly sixteen clock cycles per conversion.
// RQ5 - Steps: ref-zero, auto-zero, auto-cal, sample, nine-bit SAR, transfer, in order.
// RQ6 - Neighbour sections are one cycle apart; one section samples each cycle.
// RQ7 - The sixteen-phase pattern repeats with no gap.
// RQ8 - A sample's result appears at the output twelve cycles after sampling.
// RQ9 - Offset loop accumulates many comparator decisions against reference zero.
// RQ10 - Gain loop integrates repeated gain-error decisions per section.
// RQ11 - Only the sampling section connects to the input; others are isolated.
// RQ12 - Calibration starts at power-up and runs in background, never interrupting.
// RQ13 - Initial calibration needs at least ten thousand cycles; data unreliable before.
// RQ14 - Calibration steps launch on rising edges; clock must keep running.
// RQ15 - Offset and gain move in steps smaller than one eight-bit LSB.
// RQ16 - Output word with overrange bit is registered every rising edge.
// RQ17 - Output-enable low drives data and overrange; high releases them.
// RQ18 - Above full scale the overrange bit is one and all data bits one.
// RQ19 - Output code is straight binary, zero gives zeros, full scale ones.
// RQ20 - Phase starts at section zero; words invalid until pipeline first fills.
`timescale 1ns/10ps
`default_nettype none
`include "isq_map.vh"

module isq_top #(
  parameter CAL_CYCLES = `ISQ_CAL_CYCLES
) (
  input  wire          i_clk,               // 25 MHz conversion clock
  input  wire          i_nrst,              // Async reset, active low
  input  wire          i_ce,                // Clock enable
  input  wire          i_oe_n,              // Output enable pin, active low
  input  wire [15:0]   i_cmp,               // Per-section comparator decisions
  output reg  [143:0]  o_trial_code,        // Per-section SAR trial codes, 9 bits each
  output reg  [15:0]   o_refz_sel,          // One-hot: section sampling reference zero
  output reg  [15:0]   o_sample_sel,        // One-hot: section switched to the input
  output reg  [3:0]    o_trim_sec,          // Section whose trims are being loaded
  output reg  [7:0]    o_ofs_trim,          // Offset trim value
  output reg  [7:0]    o_gain_trim,         // Gain trim value
  output reg           o_trim_load,         // Trim load strobe
  output reg  [7:0]    o_sample_code,       // Converted code
  output reg           o_overrange_flag,    // Overrange bit
  output reg           o_data_oe,           // Drive enable for code and overrange
  output reg           o_word_valid_strobe, // Output word is a trustworthy sample
  output reg           o_cal_done           // Initial calibration period over
);

  localparam integer          CAL_LAST_I = CAL_CYCLES - 1;
  localparam [`ISQ_CNT_W-1:0] CAL_LAST   = CAL_LAST_I[`ISQ_CNT_W-1:0];
  localparam ACC_W = `ISQ_ACC_W;

  function [3:0] sec_of;
    input [3:0] ph;
    input [3:0] st;
    begin
      sec_of = ph - st;
    end
  endfunction

  function [15:0] onehot;
    input [3:0] idx;
    begin
      onehot = 16'h0001 << idx;
    end
  endfunction

  // Saturating one-count step, a sixteenth of an output LSB
  function [ACC_W-1:0] acc_step;
    input [ACC_W-1:0] acc;
    input             down;
    begin
      if (down) begin
        acc_step = (acc == `ISQ_ACC_MIN) ? acc : acc - 1'b1;
      end else begin
        acc_step = (acc == `ISQ_ACC_MAX) ? acc : acc + 1'b1;
      end
    end
  endfunction

  reg  [3:0]             ph_r;
  wire [3:0]             ph_nxt = ph_r + 4'h1;
  reg                    oe_s1_r;
  reg                    oe_s2_r;
  reg                    primed_r;
  reg                    first_r;
  reg  [`ISQ_CNT_W-1:0]  cal_cnt_r;
  reg  [ACC_W-1:0]       ofs_hold_r;
  reg  [ACC_W-1:0]       gain_hold_r;
  reg  [143:0]           sar_nxt;
  reg  [8:0]             word;
  reg  [3:0]             st;
  reg  [3:0]             b;
  integer                i;

  wire [3:0]             sec_az  = sec_of(ph_r, `ISQ_ST_AZ);
  wire [3:0]             sec_cal = sec_of(ph_r, `ISQ_ST_CAL);
  wire [3:0]             sec_xf  = sec_of(ph_r, `ISQ_ST_XFER);
  wire [2*ACC_W-1:0]     rdata;
  wire [ACC_W-1:0]       rd_ofs  = first_r ? `ISQ_ACC_MID : rdata[2*ACC_W-1:ACC_W];
  wire [ACC_W-1:0]       rd_gain = first_r ? `ISQ_ACC_MID : rdata[ACC_W-1:0];
  wire [ACC_W-1:0]       ofs_upd  = acc_step(rd_ofs, i_cmp[sec_az]);
  wire [ACC_W-1:0]       gain_upd = acc_step(gain_hold_r, i_cmp[sec_cal]);
  wire [8:0]             res = o_trial_code[sec_xf*9 +: 9];

  // Per-section trims: read one cycle ahead so data meet the auto-zero step
  isq_mem #(
    .DW (2*ACC_W),
    .AW (4)
  ) u_trim_mem (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_raddr (ph_r),
    .o_rdata (rdata),
    .i_we    (1'b1),
    .i_waddr (sec_cal),
    .i_wdata ({ofs_hold_r, gain_upd})
  );

  // SAR step for every section, each at its own phase offset
  always @* begin
    sar_nxt = o_trial_code;
    word    = 9'h000;
    st      = 4'h0;
    b       = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      st   = ph_r - i[3:0];                          // [RQ6]
      word = o_trial_code[i*9 +: 9];
      if (st == `ISQ_ST_SAMP) begin
        word = `ISQ_SAR_INIT;                        // [RQ5]
      end else if (st >= `ISQ_ST_SAR_LO && st <= `ISQ_ST_SAR_HI) begin
        b = `ISQ_ST_SAR_HI - st;                     // [RQ5]
        if (!i_cmp[i]) begin
          word[b] = 1'b0;
        end
        if (b != 4'h0) begin
          word[b-4'h1] = 1'b1;
        end
      end
      sar_nxt[i*9 +: 9] = word;                      // [RQ1]
    end
  end

  wire                   cal_end = (cal_cnt_r == CAL_LAST);

  // Phase counter and section schedule
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ph_r         <= 4'h0;
      o_trial_code <= 144'h0;
      o_refz_sel   <= `ISQ_REFZ_RST;
      o_sample_sel <= `ISQ_SAMP_RST;
      primed_r     <= 1'b0;
      first_r      <= 1'b1;
    end else if (i_ce) begin
      ph_r         <= ph_nxt;                                   // [RQ2] [RQ7] [RQ20]
      o_trial_code <= sar_nxt;                                  // [RQ4]
      o_refz_sel   <= onehot(sec_of(ph_nxt, `ISQ_ST_REFZ));     // [RQ5]
      o_sample_sel <= onehot(sec_of(ph_nxt, `ISQ_ST_SAMP));     // [RQ11]
      if (ph_r == `ISQ_PH_LAST) begin
        primed_r <= 1'b1;
      end
      // Trim memory has no reset, so the first pass must not read it
      if (ph_r == 4'h0 && primed_r) begin
        first_r <= 1'b0;
      end
    end
  end

  // Background loops: auto-zero step then auto-cal step
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cal_cnt_r   <= {`ISQ_CNT_W{1'b0}};
      ofs_hold_r  <= `ISQ_ACC_MID;
      gain_hold_r <= `ISQ_ACC_MID;
      o_trim_sec  <= 4'h0;
      o_ofs_trim  <= `ISQ_TRIM_RST;
      o_gain_trim <= `ISQ_TRIM_RST;
      o_trim_load <= 1'b0;
      o_cal_done  <= 1'b0;
    end else if (i_ce) begin
      ofs_hold_r  <= ofs_upd;                                   // [RQ9] [RQ12] [RQ14]
      gain_hold_r <= rd_gain;
      o_trim_sec  <= sec_cal;
      o_ofs_trim  <= ofs_hold_r[ACC_W-1 -: 8];                  // [RQ15]
      o_gain_trim <= gain_upd[ACC_W-1 -: 8];                    // [RQ10] [RQ15]
      o_trim_load <= 1'b1;
      // Counter parks at its end so done can never wrap back low
      if (!cal_end) begin
        cal_cnt_r <= cal_cnt_r + 1'b1;
      end
      o_cal_done  <= cal_end;                                   // [RQ13]
    end
  end

  // Output stage: pin synchroniser, result mux and valid
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      oe_s1_r             <= 1'b1;
      oe_s2_r             <= 1'b1;
      o_data_oe           <= 1'b0;
      o_sample_code       <= 8'h00;
      o_overrange_flag    <= 1'b0;
      o_word_valid_strobe <= 1'b0;
    end else if (i_ce) begin
      oe_s1_r   <= i_oe_n;
      oe_s2_r   <= oe_s1_r;
      o_data_oe <= ~oe_s2_r;                                    // [RQ17]
      // Transfer step lands 12 cycles after sampling
      if (res[8]) begin
        o_sample_code    <= 8'hFF;                              // [RQ18]
        o_overrange_flag <= 1'b1;
      end else begin
        o_sample_code    <= res[7:0];                           // [RQ3] [RQ8] [RQ16] [RQ19]
        o_overrange_flag <= 1'b0;
      end
      // Held low until section 0 has transferred its first real result and the calibration count has ended
      o_word_valid_strobe <= (primed_r || ph_r == `ISQ_PH_LAST) && cal_end; // [RQ20]
    end
  end

endmodule // isq_top

`default_nettype wire

/* inc/isq_map.vh */
`ifndef ISQ_MAP_VH
`define ISQ_MAP_VH

// Sections and schedule
`define ISQ_NSEC        16
`define ISQ_RES_W       9
`define ISQ_CODE_W      8
`define ISQ_ST_REFZ     4'h0
`define ISQ_ST_AZ       4'h1
`define ISQ_ST_CAL      4'h2
`define ISQ_ST_SAMP     4'h3
`define ISQ_ST_SAR_LO   4'h4
`define ISQ_ST_SAR_HI   4'hC
`define ISQ_ST_XFER     4'hF
`define ISQ_SAR_INIT    9'h100
`define ISQ_PH_LAST     4'hF
`define ISQ_REFZ_RST    16'h0001
`define ISQ_SAMP_RST    16'h2000
`define ISQ_TRIM_RST    8'h80

// Calibration
`define ISQ_CAL_CYCLES  10000
`define ISQ_CNT_W       14
`define ISQ_ACC_W       12
`define ISQ_ACC_MID     12'h800
`define ISQ_ACC_MAX     12'hFFF
`define ISQ_ACC_MIN     12'h000

`endif

/* testbench/isq_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module isq_chk #(parameter CAL_CYCLES = 10000) (
  input wire logic        i_clk,               // Clock
  input wire logic        i_nrst,              // Reset
  input wire logic        i_ce,                // Enable
  input wire logic        i_oe_n,              // Output enable
  input wire logic [15:0] o_refz_sel,          // Ref-zero one-hot
  input wire logic [15:0] o_sample_sel,        // Sample one-hot
  input wire logic [7:0]  o_sample_code,       // Code
  input wire logic        o_overrange_flag,    // Overrange
  input wire logic        o_data_oe,           // Drive enable
  input wire logic        o_word_valid_strobe, // Valid
  input wire logic        o_cal_done           // Cal over
);
  logic [15:0] cnt_r;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) cnt_r <= 16'h0000;
    else if (i_ce && cnt_r != 16'hFFFF) cnt_r <= cnt_r + 16'h0001;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_sample_onehot: assert property ($onehot(o_sample_sel))
    else $error("sample select not one-hot");
  a_sample_skew: assert property (o_sample_sel == {o_refz_sel[2:0], o_refz_sel[15:3]})
    else $error("sample step not three after ref-zero");
  a_phase_step: assert property (i_ce |=>
    o_refz_sel == {$past(o_refz_sel[14:0]), $past(o_refz_sel[15])})
    else $error("phase did not advance by one");
  a_over_code: assert property (o_overrange_flag |-> o_sample_code == 8'hFF)
    else $error("overrange without all-ones code");
  a_oe_drive: assert property ($fell(i_oe_n) ##1 !i_oe_n [*2] |=> o_data_oe)
    else $error("outputs not driven");
  a_oe_release: assert property ($rose(i_oe_n) ##1 i_oe_n [*2] |=> !o_data_oe)
    else $error("outputs not released");
  a_valid_cal: assert property (o_word_valid_strobe |-> o_cal_done)
    else $error("valid before calibration");
  a_cal_early: assert property (cnt_r < CAL_CYCLES |-> !o_cal_done)
    else $error("calibration done too early");
  a_cal_late: assert property (cnt_r >= CAL_CYCLES |-> o_cal_done)
    else $error("calibration done too late");
endmodule // isq_chk
bind isq_top isq_chk #(.CAL_CYCLES(CAL_CYCLES)) u_isq_chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_ce(i_ce), .i_oe_n(i_oe_n), .o_refz_sel(o_refz_sel), .o_sample_sel(o_sample_sel),
  .o_sample_code(o_sample_code), .o_overrange_flag(o_overrange_flag), .o_data_oe(o_data_oe),
  .o_word_valid_strobe(o_word_valid_strobe), .o_cal_done(o_cal_done));
`default_nettype wire

/* testbench/isq_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module isq_sink (
  input  wire logic        i_clk,  // Clock
  input  wire logic        i_en,   // Word lines driven
  input  wire logic        i_vld,  // Word valid
  input  wire logic [7:0]  i_code, // Code lines
  input  wire logic        i_ovr,  // Overrange line
  output var  logic [8:0]  o_word, // Last word taken
  output var  logic [15:0] o_cnt   // Words taken
);
  initial o_word = 9'h000;
  initial o_cnt = 16'h0000;
  // Early words are ignored, never stored
  always @(posedge i_clk) begin
    if (i_en && i_vld) begin
      o_word <= {i_ovr, i_code};
      o_cnt  <= o_cnt + 16'h0001;
    end
  end
endmodule // isq_sink
`default_nettype wire

/* testbench/isq_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module isq_top_tb;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, oe_n = 1'b0;
  logic [15:0] cmp = 16'h0000;
  logic [8:0] vin = 9'h000;
  logic [8:0] vl [6] = '{9'h000, 9'h001, 9'h0A5, 9'h0FF, 9'h100, 9'h1C3};
  wire [143:0] trial;
  wire [15:0] refz, samp, scnt;
  wire [7:0] code;
  wire [8:0] sw;
  wire ovr, doe, vld, cdone;
  wire [3:0] tsec;
  wire [7:0] otrim, gtrim;
  wire tload;
  int n_fail = 0, n_checks = 0, cyc = 0;
  isq_top #(.CAL_CYCLES(40)) u_isq_top (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_oe_n(oe_n),
    .i_cmp(cmp), .o_trial_code(trial), .o_refz_sel(refz), .o_sample_sel(samp),
    .o_trim_sec(tsec), .o_ofs_trim(otrim), .o_gain_trim(gtrim), .o_trim_load(tload),
    .o_sample_code(code),
    .o_overrange_flag(ovr), .o_data_oe(doe), .o_word_valid_strobe(vld), .o_cal_done(cdone));
  isq_sink u_isq_sink (.i_clk(clk), .i_en(doe), .i_vld(vld), .i_code(code), .i_ovr(ovr),
    .o_word(sw), .o_cnt(scnt));
  initial forever #20 clk = ~clk;
  // Ideal comparator per section: input at or above trial
  always @(negedge clk) for (int s = 0; s < 16; s++) cmp[s] <= vin >= trial[9*s +: 9];
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset();
    repeat (20) @(negedge clk);
    chk("refz", refz, 16'h0001);
    chk("samp", samp, 16'h2000);
    chk("valid", {15'h0000, vld}, 16'h0000);
    nrst = 1'b1;
  endtask
  task automatic t_cal();
    int n;
    n = 0;
    while (cdone !== 1'b1 && n < 200) begin
      chk("early", {15'h0000, vld}, 16'h0000);
      @(negedge clk);
      n++;
    end
    chk("caltime", {15'h0000, n >= 40 && n <= 42}, 16'h0001);
  endtask
  task automatic t_conv(input logic [8:0] v);
    logic [7:0] ec;
    logic [15:0] c0;
    ec = v[8] ? 8'hFF : v[7:0];
    vin = v;
    repeat (48) @(negedge clk);
    c0 = scnt;
    for (int i = 0; i < 16; i++) begin
      chk("code", {8'h00, code}, {8'h00, ec});
      chk("ovr", {15'h0000, ovr}, {15'h0000, v[8]});
      chk("valid", {15'h0000, vld}, 16'h0001);
      @(negedge clk);
    end
    chk("words", scnt - c0, 16'h0010);
    chk("word", {7'h00, sw}, {7'h00, v[8], ec});
  endtask
  // Steady input keeps each comparator at one in its auto-zero and auto-cal steps: both loops step down once a pass
  task automatic t_trim();
    logic [7:0] o0, g0, op;
    vin = 9'h0C0;
    repeat (48) @(negedge clk);
    while (tsec !== 4'h0) @(negedge clk);
    o0 = otrim;
    g0 = gtrim;
    op = otrim;
    for (int k = 0; k < 16; k++) begin
      repeat (16) @(negedge clk);
      chk("tsec", {12'h000, tsec}, 16'h0000);
      chk("tload", {15'h0000, tload}, 16'h0001);
      chk("ostep", {15'h0000, (op - otrim) <= 8'h01}, 16'h0001);
      op = otrim;
    end
    chk("otrim", {8'h00, otrim}, {8'h00, o0 - 8'h01});
    chk("gtrim", {8'h00, gtrim}, {8'h00, g0 - 8'h01});
  endtask
  task automatic t_ce();
    logic [15:0] r0;
    logic [7:0] c0;
    r0 = refz;
    c0 = code;
    ce = 1'b0;
    repeat (6) @(negedge clk);
    chk("ce_refz", refz, r0);
    chk("ce_code", {8'h00, code}, {8'h00, c0});
    ce = 1'b1;
    @(negedge clk);
    chk("ce_run", refz, {r0[14:0], r0[15]});
  endtask
  task automatic t_oe();
    logic [15:0] c0;
    oe_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("oe_off", {15'h0000, doe}, 16'h0000);
    c0 = scnt;
    repeat (8) @(negedge clk);
    chk("held", scnt, c0);
    oe_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("oe_on", {15'h0000, doe}, 16'h0001);
  endtask
  initial begin
    t_reset();
    t_cal();
    foreach (vl[i]) t_conv(vl[i]);
    t_trim();
    t_ce();
    t_oe();
    end_sim();
  end
endmodule // isq_top_tb
`default_nettype wire
